/* File: rtl/deadband_gen.sv */
// Complementary output pair with deadband and kill override
module deadband_gen #(
  parameter int DEAD_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pwm_in,
  input wire logic compl_en,
  input wire logic kill,
  input wire logic [DEAD_W-1:0] dead,
  output logic hi_out,
  output logic lo_out
);
  // Whole state of the pair
  typedef struct packed {
    logic prev;
    logic [DEAD_W-1:0] gap;
    logic hi;
    logic lo;
  } db_state_type;

  db_state_type q_r;
  db_state_type q_nxt;

  // Each edge of the compare signal opens a gap where both outputs rest low
  always_comb begin
    q_nxt = q_r;
    q_nxt.prev = pwm_in;
    if (pwm_in != q_r.prev) begin
      q_nxt.gap = dead;
    end else if (q_r.gap != '0) begin
      q_nxt.gap = q_r.gap - 1'b1;
    end
    // Both legs derive from one sampled level, so they can never overlap
    q_nxt.hi = pwm_in && (q_nxt.gap == '0);
    q_nxt.lo = !pwm_in && compl_en && (q_nxt.gap == '0);
    // Kill wins over everything
    if (kill) begin
      q_nxt.hi = 1'b0;
      q_nxt.lo = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign hi_out = q_r.hi;
  assign lo_out = q_r.lo;
endmodule : deadband_gen

/* File: rtl/pin_sync.sv */
// Two-flop synchroniser for a group of asynchronous inputs
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d_async,
  output logic [WIDTH-1:0] q_sync
);
  // First stage feeds only the second stage
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_state_type;

  sync_state_type q_r;
  sync_state_type q_nxt;

  // Shift the pins through both stages
  always_comb begin
    q_nxt.meta = d_async;
    q_nxt.sync = q_r.meta;
  end

  // Both stages clear under reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q_sync = q_r.sync;
endmodule : pin_sync

/* File: rtl/timer_block.sv */
// Four 16-bit down-counting timer, counter and PWM units with register port
//
// Summary of operation
// - Sixteen-bit counter, counts down only
// - Period loads on start, reset, terminal count
// - Comparator relation LT, LTE, EQ, GTE, GT
// - Interrupt on terminal count, compare, capture
// - Compare, terminal count, optional complementary outputs
// - Free running, one shot, or enable gated
// - One shot stops after one period
// - Gated mode decrements only while enable high
// - Capture input latches full counter value
// - Kill input overrides comparator outputs
// - Complementary pair separated by deadband gap
// - Counting clock from selectable sources
// - Four independent timer instances
`include "timer_defines.svh"

module timer_block (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic [timer_pkg::NUM_TMR-1:0] enable_pin,
  input wire logic [timer_pkg::NUM_TMR-1:0] reset_pin,
  input wire logic [timer_pkg::NUM_TMR-1:0] capture_pin,
  input wire logic [timer_pkg::NUM_TMR-1:0] kill_pin,
  input wire logic [timer_pkg::NUM_TMR-1:0] ext_clk_pin,
  output logic [timer_pkg::NUM_TMR-1:0] cmp_out,
  output logic [timer_pkg::NUM_TMR-1:0] cmp_n_out,
  output logic [timer_pkg::NUM_TMR-1:0] tc_out,
  output logic [timer_pkg::NUM_TMR-1:0] irq_line,
  output logic irq
);
  import timer_pkg::*;

  localparam int NEV = NUM_TMR * `EV_PER_TMR;

  // Whole state of the block
  typedef struct packed {
    chan_state_type [NUM_TMR-1:0] ch;
    logic [NEV-1:0] status;
    logic [NEV-1:0] mask;
    logic [15:0] prescale;
    logic [15:0] div_cnt;
    logic div_tick;
    logic [31:0] rdata;
    logic [NUM_TMR-1:0] irq_line;
    logic irq;
  } top_state_type;

  top_state_type q_r;
  top_state_type q_nxt;

  // Synchronised pins
  logic [NUM_TMR-1:0] en_s;
  logic [NUM_TMR-1:0] rst_s;
  logic [NUM_TMR-1:0] cap_s;
  logic [NUM_TMR-1:0] kill_s;
  logic [NUM_TMR-1:0] ext_s;

  // Every pin comes from outside the clock domain
  pin_sync #(
    .WIDTH(5 * NUM_TMR)
  ) u_pins (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d_async({enable_pin, reset_pin, capture_pin, kill_pin, ext_clk_pin}),
    .q_sync({en_s, rst_s, cap_s, kill_s, ext_s})
  );

  // Comparator with the five relations; spare codes never compare true
  function automatic logic cmp_eval(input cmp_rel_type rel, input logic [15:0] cnt,
                                    input logic [15:0] cmpv);
    logic res;
    res = 1'b0;
    unique case (rel)
      REL_LT: res = cnt < cmpv;
      REL_LTE: res = cnt <= cmpv;
      REL_EQ: res = cnt == cmpv;
      REL_GTE: res = cnt >= cmpv;
      REL_GT: res = cnt > cmpv;
      default: res = 1'b0;
    endcase
    return res;
  endfunction : cmp_eval

  // Per-timer helper terms; all but tick_v are used by the main process and by the checks
  logic [NUM_TMR-1:0] tick_v;
  logic [NUM_TMR-1:0] step_v;
  logic [NUM_TMR-1:0] rst_e;
  logic [NUM_TMR-1:0] cap_e;

  // Counting enables per timer
  always_comb begin
    for (int i = 0; i < NUM_TMR; i++) begin
      // Pick the counting clock as an enable pulse
      unique case (q_r.ch[i].clk_sel)
        CLK_SYS: tick_v[i] = 1'b1;
        CLK_DIV: tick_v[i] = q_r.div_tick;
        CLK_EXT_RISE: tick_v[i] = ext_s[i] & ~q_r.ch[i].ext_prev;
        CLK_EXT_FALL: tick_v[i] = ~ext_s[i] & q_r.ch[i].ext_prev;
      endcase
      // Gated mode steps only while the enable pin is high
      step_v[i] = tick_v[i] & q_r.ch[i].running &
                  ((q_r.ch[i].mode != MODE_GATED) | en_s[i]);
      rst_e[i] = rst_s[i] & ~q_r.ch[i].rst_prev;
      cap_e[i] = cap_s[i] & ~q_r.ch[i].cap_prev;
    end
  end

  // Next state of the whole block
  always_comb begin
    chan_state_type c;
    logic [NEV-1:0] ev;
    logic [NEV-1:0] w1c;
    logic [1:0] ci;
    c = '0;
    ev = '0;
    w1c = '0;
    ci = addr[6:5];
    q_nxt = q_r;
    q_nxt.rdata = '0;

    // Shared prescaler: one tick every prescale+1 cycles
    if (q_r.div_cnt == 16'h0000) begin
      q_nxt.div_cnt = q_r.prescale;
      q_nxt.div_tick = 1'b1;
    end else begin
      q_nxt.div_cnt = q_r.div_cnt - 16'h0001;
      q_nxt.div_tick = 1'b0;
    end

    // Four copies of the same counter
    for (int i = 0; i < NUM_TMR; i++) begin
      c = q_r.ch[i];
      c.tc = 1'b0;
      if (rst_e[i]) begin
        // Reset input reloads the period
        c.count = c.period;
      end else if (step_v[i]) begin
        if (c.count == 16'h0000) begin
          // Zero: reload and flag terminal count
          c.count = c.period;
          c.tc = 1'b1;
          // One shot ends its run here
          if (c.mode == MODE_ONESHOT) begin
            c.running = 1'b0;
            c.enable = 1'b0;
          end
        end else begin
          // Down count only
          c.count = c.count - 16'h0001;
        end
      end
      // Capture the full counter value
      if (cap_e[i]) begin
        c.capture = q_r.ch[i].count;
      end
      // Compare result, before kill and deadband
      c.cmp = cmp_eval(c.rel, q_r.ch[i].count, c.compare);
      // Event flags for this timer
      ev[i*`EV_PER_TMR + `EV_TC] = c.tc;
      ev[i*`EV_PER_TMR + `EV_CMP] = c.cmp & ~q_r.ch[i].cmp;
      ev[i*`EV_PER_TMR + `EV_CAP] = cap_e[i];
      c.rst_prev = rst_s[i];
      c.cap_prev = cap_s[i];
      c.ext_prev = ext_s[i];
      q_nxt.ch[i] = c;
    end

    // Register writes
    if (wr_en) begin
      if (!addr[7]) begin
        unique case (addr[4:0])
          `OFS_CTRL: begin
            // A rising enable starts the run from a fresh period
            if (wr_data[`CTRL_EN_BIT] && !q_r.ch[ci].enable) begin
              q_nxt.ch[ci].count = q_nxt.ch[ci].period;
              q_nxt.ch[ci].running = 1'b1;
            end else if (!wr_data[`CTRL_EN_BIT]) begin
              q_nxt.ch[ci].running = 1'b0;
            end
            q_nxt.ch[ci].enable = wr_data[`CTRL_EN_BIT];
            q_nxt.ch[ci].mode = count_mode_type'(wr_data[`CTRL_MODE_LSB +: 2]);
            q_nxt.ch[ci].rel = cmp_rel_type'(wr_data[`CTRL_REL_LSB +: 3]);
            q_nxt.ch[ci].clk_sel = clk_src_type'(wr_data[`CTRL_CLK_LSB +: 2]);
            q_nxt.ch[ci].compl = wr_data[`CTRL_COMPL_BIT];
          end
          `OFS_PERIOD: q_nxt.ch[ci].period = wr_data[15:0];
          `OFS_COMPARE: q_nxt.ch[ci].compare = wr_data[15:0];
          `OFS_DEADBAND: q_nxt.ch[ci].dead = wr_data[7:0];
          default: begin
            // Read-only or unmapped: write ignored
          end
        endcase
      end else begin
        unique case (addr)
          `OFS_STATUS: w1c = wr_data[NEV-1:0];
          `OFS_MASK: q_nxt.mask = wr_data[NEV-1:0];
          `OFS_PRESCALE: q_nxt.prescale = wr_data[15:0];
          default: begin
            // Unmapped: write ignored
          end
        endcase
      end
    end

    // Sticky flags: a new event wins over a clearing write
    q_nxt.status = (q_r.status & ~w1c) | ev;

    // One line per timer plus the combined request
    for (int i = 0; i < NUM_TMR; i++) begin
      q_nxt.irq_line[i] = |(q_nxt.status[i*`EV_PER_TMR +: `EV_PER_TMR] &
                            q_nxt.mask[i*`EV_PER_TMR +: `EV_PER_TMR]);
    end
    q_nxt.irq = |(q_nxt.status & q_nxt.mask);

    // Read data stand the cycle after the strobe; unmapped reads zero
    if (rd_en) begin
      if (!addr[7]) begin
        unique case (addr[4:0])
          `OFS_CTRL: begin
            q_nxt.rdata[`CTRL_EN_BIT] = q_r.ch[ci].running;
            q_nxt.rdata[`CTRL_MODE_LSB +: 2] = q_r.ch[ci].mode;
            q_nxt.rdata[`CTRL_REL_LSB +: 3] = q_r.ch[ci].rel;
            q_nxt.rdata[`CTRL_CLK_LSB +: 2] = q_r.ch[ci].clk_sel;
            q_nxt.rdata[`CTRL_COMPL_BIT] = q_r.ch[ci].compl;
          end
          `OFS_PERIOD: q_nxt.rdata[15:0] = q_r.ch[ci].period;
          `OFS_COMPARE: q_nxt.rdata[15:0] = q_r.ch[ci].compare;
          `OFS_COUNT: q_nxt.rdata[15:0] = q_r.ch[ci].count;
          `OFS_CAPTURE: q_nxt.rdata[15:0] = q_r.ch[ci].capture;
          `OFS_DEADBAND: q_nxt.rdata[7:0] = q_r.ch[ci].dead;
          default: q_nxt.rdata = '0;
        endcase
      end else begin
        unique case (addr)
          `OFS_STATUS: q_nxt.rdata[NEV-1:0] = q_r.status;
          `OFS_MASK: q_nxt.rdata[NEV-1:0] = q_r.mask;
          `OFS_PRESCALE: q_nxt.rdata[15:0] = q_r.prescale;
          default: q_nxt.rdata = '0;
        endcase
      end
    end
  end

  // State register with documented reset values
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= '0;
      for (int i = 0; i < NUM_TMR; i++) begin
        q_r.ch[i].count <= `RST_PERIOD;
        q_r.ch[i].period <= `RST_PERIOD;
        q_r.ch[i].compare <= `RST_COMPARE;
        q_r.ch[i].dead <= `RST_DEAD;
      end
      q_r.prescale <= `RST_PRESCALE;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Output stages: kill and deadband sit after the comparator
  for (genvar g = 0; g < NUM_TMR; g++) begin : g_out
    // Kill forces both legs low, gap keeps them apart
    deadband_gen #(
      .DEAD_W(8)
    ) u_db (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pwm_in(q_r.ch[g].cmp),
      .compl_en(q_r.ch[g].compl),
      .kill(kill_s[g]),
      .dead(q_r.ch[g].dead),
      .hi_out(cmp_out[g]),
      .lo_out(cmp_n_out[g])
    );
  end

  // Registered outputs
  assign tc_out = {q_r.ch[3].tc, q_r.ch[2].tc, q_r.ch[1].tc, q_r.ch[0].tc};
  assign irq_line = q_r.irq_line;
  assign irq = q_r.irq;
  assign rd_data = q_r.rdata;

  // Checks on every timer
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  for (genvar g = 0; g < NUM_TMR; g++) begin : g_chk
    chk_count_down: assert property (
      step_v[g] && !rst_e[g] && q_r.ch[g].count != 16'h0000
      |=> q_r.ch[g].count == $past(q_r.ch[g].count) - 16'h0001)
      else $error("counter did not step down by one");
    chk_tc_reload: assert property (
      $rose(tc_out[g]) |-> q_r.ch[g].count == $past(q_r.ch[g].period) && $past(step_v[g]))
      else $error("terminal count without period reload");
    chk_reset_reload: assert property (
      rst_e[g] && !wr_en |=> q_r.ch[g].count == $past(q_r.ch[g].period))
      else $error("reset input did not reload period");
    chk_oneshot_stop: assert property (
      tc_out[g] && q_r.ch[g].mode == MODE_ONESHOT && !$past(wr_en) |-> !q_r.ch[g].running)
      else $error("one shot kept running after period");
    chk_gate_hold: assert property (
      q_r.ch[g].mode == MODE_GATED && !en_s[g] && !rst_e[g] && !wr_en
      |=> $stable(q_r.ch[g].count))
      else $error("gated counter moved with enable low");
    chk_capture_value: assert property (
      cap_e[g] |=> q_r.ch[g].capture == $past(q_r.ch[g].count))
      else $error("capture did not hold counter value");
    chk_cmp_equal: assert property (
      q_r.ch[g].rel == REL_EQ && $stable(q_r.ch[g].rel)
      |-> q_r.ch[g].cmp == ($past(q_r.ch[g].count) == $past(q_r.ch[g].compare)))
      else $error("equal relation gave wrong compare result");
    chk_kill_low: assert property (
      kill_s[g] |=> !cmp_out[g] && !cmp_n_out[g])
      else $error("outputs active while killed");
    chk_no_overlap: assert property (
      !(cmp_out[g] && cmp_n_out[g]))
      else $error("complementary outputs overlap");
    // A compare edge with a nonzero gap must leave both legs low next cycle
    chk_dead_gap: assert property (
      $changed(q_r.ch[g].cmp) && q_r.ch[g].dead != 8'h00 |=> !cmp_out[g] && !cmp_n_out[g])
      else $error("compare edge did not open a deadband gap");
    chk_tc_flag: assert property (
      tc_out[g] |-> q_r.status[g*`EV_PER_TMR + `EV_TC])
      else $error("terminal count not flagged");
  end

  // Main scenarios
  cov_oneshot_end: cover property (tc_out[0] && q_r.ch[0].mode == MODE_ONESHOT);
  cov_capture: cover property (cap_e[0] ##1 irq);
  // Kill and the complementary pair are exercised on timer 1
  cov_kill_active: cover property (q_r.ch[1].cmp && kill_s[1]);
  cov_deadband: cover property ($fell(cmp_out[1]) ##2 cmp_n_out[1]);
endmodule : timer_block

/* File: shared/timer_defines.svh */
// Register offsets, field positions, status layout and reset values of the timer block
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// Per-timer register window: timer n sits at n * TMR_STRIDE
`define TMR_STRIDE 8'h20
`define OFS_CTRL 5'h00
`define OFS_PERIOD 5'h04
`define OFS_COMPARE 5'h08
`define OFS_COUNT 5'h0c
`define OFS_CAPTURE 5'h10
`define OFS_DEADBAND 5'h14

// Shared registers above the timer windows
`define OFS_STATUS 8'h80
`define OFS_MASK 8'h84
`define OFS_PRESCALE 8'h88

// Control register fields
`define CTRL_EN_BIT 0
`define CTRL_MODE_LSB 1
`define CTRL_REL_LSB 3
`define CTRL_CLK_LSB 6
`define CTRL_COMPL_BIT 8

// Status and mask layout: three bits per timer
`define EV_PER_TMR 3
`define EV_TC 0
`define EV_CMP 1
`define EV_CAP 2

// Reset values
`define RST_PERIOD 16'hffff
`define RST_COMPARE 16'h8000
`define RST_DEAD 8'h00
`define RST_PRESCALE 16'h0000

`endif

/* File: shared/timer_pkg.sv */
// Types shared by the timer, counter and PWM block
package timer_pkg;

  // Number of timer instances
  localparam int NUM_TMR = 4;

  // Counting behaviour
  typedef enum logic [1:0] {MODE_FREE, MODE_ONESHOT, MODE_GATED, MODE_SPARE} count_mode_type;

  // Comparator relation, counter against compare value
  typedef enum logic [2:0] {REL_LT, REL_LTE, REL_EQ, REL_GTE, REL_GT, REL_X5, REL_X6, REL_X7}
    cmp_rel_type;

  // Counting clock source
  typedef enum logic [1:0] {CLK_SYS, CLK_DIV, CLK_EXT_RISE, CLK_EXT_FALL} clk_src_type;

  // State of one timer
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] period;
    logic [15:0] compare;
    logic [15:0] capture;
    logic [7:0] dead;
    logic enable;
    count_mode_type mode;
    cmp_rel_type rel;
    clk_src_type clk_sel;
    logic compl;
    logic running;
    logic rst_prev;
    logic cap_prev;
    logic ext_prev;
    logic cmp;
    logic tc;
  } chan_state_type;

endpackage : timer_pkg

/* File: tb/pin_model.sv */
// Model of the routed logic and pins that feed the timer inputs
module pin_model (
  input wire logic clk_sys,
  input wire logic [3:0] en_lvl,
  input wire logic [3:0] rst_lvl,
  input wire logic [3:0] cap_lvl,
  input wire logic [3:0] kill_lvl,
  input wire logic ext_run,
  output logic [3:0] enable_pin,
  output logic [3:0] reset_pin,
  output logic [3:0] capture_pin,
  output logic [3:0] kill_pin,
  output logic [3:0] ext_clk_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ext_div_r; // Divider for the external count clock

  // Pins move only just after a rising edge and hold whole cycles
  always @(posedge clk_sys) begin
    enable_pin <= en_lvl;
    reset_pin <= rst_lvl;
    capture_pin <= cap_lvl;
    kill_pin <= kill_lvl;
    // External clock stands still at low when not running
    ext_div_r <= ext_run ? ext_div_r + 2'h1 : 2'h0;
    ext_clk_pin <= {4{ext_div_r[1]}};
  end
endmodule : pin_model

/* File: tb/timer_counter_pwm_16bit_test.sv */
// Self-checking testbench of the four-unit timer block
`include "timer_defines.svh"

module timer_counter_pwm_16bit_test;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rd_data;
  logic [3:0] en_lvl = 4'h0, rst_lvl = 4'h0, cap_lvl = 4'h0, kill_lvl = 4'h0;
  logic ext_run = 1'b0;
  logic [3:0] enable_pin, reset_pin, capture_pin, kill_pin, ext_clk_pin;
  logic [3:0] cmp_out, cmp_n_out, tc_out, irq_line;
  logic irq;
  int fail_count = 0;
  int checks = 0;

  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  pin_model pins (.clk_sys(clk_sys), .en_lvl(en_lvl), .rst_lvl(rst_lvl), .cap_lvl(cap_lvl),
    .kill_lvl(kill_lvl), .ext_run(ext_run), .enable_pin(enable_pin), .reset_pin(reset_pin),
    .capture_pin(capture_pin), .kill_pin(kill_pin), .ext_clk_pin(ext_clk_pin));

  timer_block dut (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .enable_pin(enable_pin),
    .reset_pin(reset_pin), .capture_pin(capture_pin), .kill_pin(kill_pin),
    .ext_clk_pin(ext_clk_pin), .cmp_out(cmp_out), .cmp_n_out(cmp_n_out), .tc_out(tc_out),
    .irq_line(irq_line), .irq(irq));

  // Register byte address of one timer's register
  function automatic logic [7:0] ra(input int ch, input logic [4:0] ofs);
    return 8'(ch) * `TMR_STRIDE + {3'h0, ofs};
  endfunction : ra

  // Control word from its fields
  function automatic logic [31:0] ctl(input int md, input int rel, input int cs, input int cp);
    return 32'h1 | 32'(md << `CTRL_MODE_LSB) | 32'(rel << `CTRL_REL_LSB)
      | 32'(cs << `CTRL_CLK_LSB) | 32'(cp << `CTRL_COMPL_BIT);
  endfunction : ctl

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr

  // One-cycle read strobe; data is taken in the following cycle only
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask : rd

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic chk_pin(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_pin

  // Read a register and compare the bits under a mask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk_val(what, exp, d & m);
  endtask : rd_chk

  // Cycles between two terminal count pulses of one timer
  task automatic tc_gap(input int ch, input int exp);
    int n;
    n = 0;
    while (tc_out[ch] !== 1'b1 && n < 300) begin
      @(posedge clk_sys);
      #1 n++;
    end
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (tc_out[ch] !== 1'b1 && n < 300);
    chk_val("tc_interval", 32'(exp), 32'(n));
  endtask : tc_gap

  task automatic t_reset_values();
    rd_chk("period_rst", ra(0, `OFS_PERIOD), 32'hffffffff, 32'(`RST_PERIOD));
    rd_chk("compare_rst", ra(2, `OFS_COMPARE), 32'hffffffff, 32'(`RST_COMPARE));
    rd_chk("ctrl_rst", ra(3, `OFS_CTRL), 32'hffffffff, 32'h0);
    rd_chk("status_rst", `OFS_STATUS, 32'hffffffff, 32'h0);
    rd_chk("unmapped", 8'h8c, 32'hffffffff, 32'h0);
    $display("test reset_values done");
  endtask : t_reset_values

  task automatic t_free_run();
    wr(ra(0, `OFS_PERIOD), 32'h2);
    wr(`OFS_MASK, 32'h1);
    wr(ra(0, `OFS_CTRL), ctl(0, 0, 0, 0));
    tc_gap(0, 3);
    tc_gap(0, 3);
    wr(ra(0, `OFS_CTRL), 32'h0);
    rd_chk("tc_status", `OFS_STATUS, 32'h1, 32'h1);
    cyc(2);
    chk_pin("irq_set", 1'b1, irq);
    chk_pin("irq_line_set", 1'b1, irq_line[0]);
    wr(`OFS_STATUS, 32'hfff);
    cyc(3);
    chk_pin("irq_clr", 1'b0, irq);
    rd_chk("status_clr", `OFS_STATUS, 32'h1, 32'h0);
    $display("test free_run done");
  endtask : t_free_run

  task automatic t_one_shot();
    int n;
    n = 0;
    wr(ra(0, `OFS_PERIOD), 32'h3);
    wr(ra(0, `OFS_CTRL), ctl(1, 0, 0, 0));
    repeat (40) begin
      @(posedge clk_sys);
      #1 if (tc_out[0] === 1'b1) n++;
    end
    chk_val("oneshot_tc_count", 32'h1, 32'(n));
    // Stopped, with the one-shot mode field still reading back
    rd_chk("oneshot_stopped", ra(0, `OFS_CTRL), 32'h1ff, 32'h2);
    $display("test one_shot done");
  endtask : t_one_shot

  // Gated count, capture, reset reload and read-only count
  task automatic t_gated();
    wr(ra(0, `OFS_PERIOD), 32'h40);
    wr(ra(0, `OFS_CTRL), ctl(2, 0, 0, 0));
    cyc(6);
    rd_chk("gated_hold", ra(0, `OFS_COUNT), 32'hffff, 32'h40);
    en_lvl[0] <= 1'b1;
    cyc(5);
    en_lvl[0] <= 1'b0;
    cyc(6);
    rd_chk("gated_count", ra(0, `OFS_COUNT), 32'hffff, 32'h3b);
    cap_lvl[0] <= 1'b1;
    cyc(2);
    cap_lvl[0] <= 1'b0;
    cyc(6);
    rd_chk("capture", ra(0, `OFS_CAPTURE), 32'hffffffff, 32'h3b);
    rd_chk("cap_status", `OFS_STATUS, 32'h4, 32'h4);
    rst_lvl[0] <= 1'b1;
    cyc(2);
    rst_lvl[0] <= 1'b0;
    cyc(6);
    wr(ra(0, `OFS_COUNT), 32'h1111);
    rd_chk("reset_reload", ra(0, `OFS_COUNT), 32'hffff, 32'h40);
    wr(ra(0, `OFS_CTRL), 32'h0);
    $display("test gated done");
  endtask : t_gated

  // Every relation code with count equal to compare, then kill and deadband
  task automatic t_compare_kill();
    logic e;
    int gap;
    wr(ra(1, `OFS_PERIOD), 32'h10);
    wr(ra(1, `OFS_COMPARE), 32'h10);
    for (int r = 0; r < 8; r++) begin
      wr(ra(1, `OFS_CTRL), ctl(2, r, 0, 1));
      cyc(6);
      e = (r >= 1 && r <= 3);
      chk_pin("cmp_rel", e, cmp_out[1]);
      chk_pin("cmp_n_rel", ~e, cmp_n_out[1]);
    end
    wr(ra(1, `OFS_CTRL), ctl(2, 3, 0, 1));
    kill_lvl[1] <= 1'b1;
    cyc(6);
    chk_pin("kill_cmp", 1'b0, cmp_out[1]);
    chk_pin("kill_cmp_n", 1'b0, cmp_n_out[1]);
    kill_lvl[1] <= 1'b0;
    wr(ra(1, `OFS_CTRL), ctl(2, 0, 0, 1));
    wr(ra(1, `OFS_DEADBAND), 32'h4);
    cyc(12);
    wr(ra(1, `OFS_CTRL), ctl(2, 3, 0, 1));
    gap = 0;
    repeat (20) begin
      @(posedge clk_sys);
      #1 chk_pin("no_overlap", 1'b0, cmp_out[1] & cmp_n_out[1]);
      if (cmp_out[1] === 1'b0 && cmp_n_out[1] === 1'b0) gap++;
    end
    // Both legs rest low for exactly the programmed gap of 4 cycles
    chk_val("dead_gap", 32'h4, 32'(gap));
    wr(ra(1, `OFS_CTRL), 32'h0);
    $display("test compare_kill done");
  endtask : t_compare_kill

  // Prescaled tick on timer 2, external edges on timer 3
  task automatic t_clock_src();
    wr(`OFS_PRESCALE, 32'h1);
    wr(ra(2, `OFS_PERIOD), 32'h2);
    // Spare mode code 3 must count exactly like free run
    wr(ra(2, `OFS_CTRL), ctl(3, 0, 1, 0));
    tc_gap(2, 6);
    wr(ra(2, `OFS_CTRL), 32'h0);
    wr(ra(3, `OFS_PERIOD), 32'h1);
    ext_run <= 1'b1;
    for (int s = 2; s < 4; s++) begin
      wr(ra(3, `OFS_CTRL), ctl(0, 0, s, 0));
      tc_gap(3, 8);
      wr(ra(3, `OFS_CTRL), 32'h0);
    end
    ext_run <= 1'b0;
    $display("test clock_src done");
  endtask : t_clock_src

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    cyc(16);
    rst_n <= 1'b1;
    cyc(3);
    t_reset_values();
    t_free_run();
    t_one_shot();
    t_gated();
    t_compare_kill();
    t_clock_src();
    summarize();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
endmodule : timer_counter_pwm_16bit_test
